// ---- verilog/ddchb_params.svh ----
// Purpose: register map, field positions, reset values and filter constants of the chain
// Assumes: included by bare name from every file that needs it
// Notes: addresses are Wishbone byte addresses; coefficients sit innermost first, so the outermost lands lowest
`ifndef DDCHB_PARAMS_SVH
`define DDCHB_PARAMS_SVH

`define DDCHB_CTRL0_ADDR 12'h310
`define DDCHB_CTRL1_ADDR 12'h330
`define DDCHB_STATUS_ADDR 12'h3F0
`define DDCHB_CTRL_RESET 8'h00
`define DDCHB_ST_MASK0_LSB 0
`define DDCHB_ST_MASK1_LSB 4
`define DDCHB_ST_CNT0_LSB 16
`define DDCHB_ST_CNT1_LSB 24

`define DDCHB_FIRST_NTAP 11
`define DDCHB_FIRST_CW 15
`define DDCHB_FIRST_NOUT 3
`define DDCHB_FIRST_CENTRE 24'sh002000
`define DDCHB_FIRST_COEF {24'sh0012C5, -24'sh000328, 24'sh000063}

`define DDCHB_SECOND_NTAP 11
`define DDCHB_SECOND_CW 18
`define DDCHB_SECOND_NOUT 3
`define DDCHB_SECOND_CENTRE 24'sh010000
`define DDCHB_SECOND_COEF {24'sh0096AA, -24'sh001A05, 24'sh00035B}

`define DDCHB_THIRD_NTAP 19
`define DDCHB_THIRD_CW 19
`define DDCHB_THIRD_NOUT 5
`define DDCHB_THIRD_CENTRE 24'sh020000
`define DDCHB_THIRD_COEF {24'sh013920, -24'sh004B48, 24'sh0016B6, -24'sh000530, 24'sh0000A1}

`define DDCHB_FINAL_NTAP 55
`define DDCHB_FINAL_CW 21
`define DDCHB_FINAL_NOUT 14
`define DDCHB_FINAL_CENTRE 24'sh080000
`define DDCHB_FINAL_COEF {24'sh051010, -24'sh019BE2, 24'sh00E07C, -24'sh008A94, \
    24'sh005870, -24'sh00382F, 24'sh0022C7, -24'sh0014A4, 24'sh000B94, -24'sh000608, \
    24'sh0002DA, -24'sh00012E, 24'sh000066, -24'sh000018}

`endif

// ---- verilog/ddchb_pkg.sv ----
// Purpose: types shared by the decimation chain and its filter stages
// Assumes: 16-bit signed samples on every rail
// Notes: none
package ddchb_pkg;

    typedef struct packed {
        logic [15:0] i;
        logic [15:0] q;
    } ddchb_sample_t;

    // decimation field: which optional stages run
    typedef enum logic [1:0] {
        DEC_THIRD = 2'h0,
        DEC_SECOND = 2'h1,
        DEC_ALL = 2'h2,
        DEC_FINAL = 2'h3
    } ddchb_dec_t;

    // quarter-rate mixer phase, gray along its cycle
    typedef enum logic [1:0] {
        MIX_P0 = 2'h0,
        MIX_P1 = 2'h1,
        MIX_P2 = 2'h3,
        MIX_P3 = 2'h2
    } ddchb_mix_t;

    typedef struct packed {
        logic spare7;
        logic gain6db;
        logic [1:0] spare54;
        logic toReal;
        logic spare2;
        ddchb_dec_t decim;
    } ddchb_ctrl_t;

    typedef struct packed {
        ddchb_ctrl_t [1:0] ctrl;
        logic ack;
        logic [31:0] rdData;
        ddchb_sample_t [1:0] outSample;
        logic [1:0] outValid;
        logic [1:0] outReal;
        ddchb_mix_t [1:0] mixPhase;
        logic [1:0][7:0] outCount;
    } ddchb_state_t;

    // clamp a wide signed value to a 16-bit sample
    function automatic logic [15:0] sat16(input logic signed [47:0] v);
        if (v > 48'sh7FFF) begin
            return 16'h7FFF;
        end else if (v < -48'sh8000) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction

endpackage

// ---- verilog/ddchb_halfband.sv ----
// Purpose: one symmetric half-band stage, I and Q rails side by side
// Assumes: at most one input per cycle; COEF holds nonzero outer taps, outermost lowest
// Notes: full parallel sum, one cycle of latency; bypass passes samples through registered
`timescale 1ns/1ps
module ddchb_halfband #(
    parameter int NTAP = 11,
    parameter int CW = 15,
    parameter int NOUT = 3,
    parameter logic [NOUT*24-1:0] COEF = '0,
    parameter logic [23:0] CENTRE = 24'h000000
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // mode
    input wire logic bypass,
    input wire logic decimate,
    // sample in
    input wire logic inValid,
    input wire ddchb_pkg::ddchb_sample_t inSample,
    // sample out
    output logic outValid,
    output ddchb_pkg::ddchb_sample_t outSample
);
    import ddchb_pkg::*;

    typedef struct packed {
        logic [NTAP-1:0][15:0] lineI;
        logic [NTAP-1:0][15:0] lineQ;
        logic phase;
        logic valid;
        ddchb_sample_t samp;
    } ddchb_hb_state_t;

    ddchb_hb_state_t state_ff;
    ddchb_hb_state_t nxt_state;

    // symmetric pre-add halves the multipliers; zero taps are never summed
    function automatic logic [15:0] firSum(input logic [NTAP-1:0][15:0] line);
        logic signed [47:0] acc;
        logic signed [47:0] pre;
        acc = 48'($signed(line[(NTAP-1)/2])) * 48'($signed(CENTRE));
        for (int k = 0; k < NOUT; k++) begin
            pre = 48'($signed(line[2*k])) + 48'($signed(line[NTAP-1-2*k]));
            acc = acc + pre * 48'($signed(COEF[k*24 +: 24]));
        end
        acc = (acc + (48'sh1 <<< (CW - 2))) >>> (CW - 1);
        return sat16(acc);
    endfunction

    always_comb begin
        nxt_state = state_ff;
        nxt_state.valid = 1'b0;
        if (bypass) begin
            nxt_state.phase = 1'b0;
            nxt_state.valid = inValid;
            if (inValid) begin
                nxt_state.samp = inSample;
            end
        end else if (inValid) begin
            nxt_state.lineI = {state_ff.lineI[NTAP-2:0], inSample.i};
            nxt_state.lineQ = {state_ff.lineQ[NTAP-2:0], inSample.q};
            nxt_state.phase = decimate ? !state_ff.phase : 1'b0;
            // one output per two inputs, or every input when not decimating
            if (!decimate || state_ff.phase) begin
                nxt_state.valid = 1'b1;
                nxt_state.samp.i = firSum(nxt_state.lineI);
                nxt_state.samp.q = firSum(nxt_state.lineQ);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign outValid = state_ff.valid;
    assign outSample = state_ff.samp;

endmodule

// ---- verilog/ddchb_chain.sv ----
// Purpose: two converters' decimation chains, gain and real conversion, Wishbone registers
// Assumes: one input sample per cycle at most per converter; master follows classic cycles
// Notes: filter lines are not flushed on a control change; drop the first outputs after one
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "ddchb_params.svh"
module ddchb_chain (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [11:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    // samples from the mixers, one lane per converter
    input wire logic [1:0] inValid,
    input wire ddchb_pkg::ddchb_sample_t [1:0] inSample,
    // samples toward the framer
    output logic [1:0] outValid,
    output ddchb_pkg::ddchb_sample_t [1:0] outSample,
    output logic [1:0] outReal
);
    import ddchb_pkg::*;

    ddchb_state_t state_ff;
    ddchb_state_t nxt_state;
    logic [1:0][4:0] stgValid;
    ddchb_sample_t [1:0][4:0] stgSample;

    // bit 0 first, 1 second, 2 third, 3 final stage running
    function automatic logic [3:0] stageMask(input ddchb_dec_t dec);
        case (dec)
            DEC_ALL: return 4'hF;
            DEC_SECOND: return 4'hE;
            DEC_THIRD: return 4'hC;
            DEC_FINAL: return 4'h8;
            default: return 4'h8;
        endcase
    endfunction

    function automatic logic isAddr(input logic [11:0] adr, input logic [11:0] base);
        return adr[11:2] == base[11:2];
    endfunction

    // 6 dB is a doubling, saturated so a full-scale input clips rather than wraps
    function automatic ddchb_sample_t applyGain(input ddchb_sample_t x, input logic on);
        ddchb_sample_t y;
        y = x;
        if (on) begin
            y.i = sat16(48'($signed(x.i)) <<< 1);
            y.q = sat16(48'($signed(x.q)) <<< 1);
        end
        return y;
    endfunction

    // real part of x times j^n; negation saturates so -32768 does not wrap
    function automatic logic [15:0] upMixReal(input ddchb_sample_t x, input ddchb_mix_t ph);
        case (ph)
            MIX_P0: return x.i;
            MIX_P1: return sat16(-48'($signed(x.q)));
            MIX_P2: return sat16(-48'($signed(x.i)));
            MIX_P3: return x.q;
            default: return x.i;
        endcase
    endfunction

    function automatic ddchb_mix_t nextPhase(input ddchb_mix_t ph);
        case (ph)
            MIX_P0: return MIX_P1;
            MIX_P1: return MIX_P2;
            MIX_P2: return MIX_P3;
            MIX_P3: return MIX_P0;
            default: return MIX_P0;
        endcase
    endfunction

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gDdc
            logic [3:0] stageOn;
            assign stageOn = stageMask(state_ff.ctrl[g].decim);
            assign stgValid[g][0] = inValid[g];
            assign stgSample[g][0] = inSample[g];

            // chain order first, second, third, final
            ddchb_halfband #(
                .NTAP(`DDCHB_FIRST_NTAP),
                .CW(`DDCHB_FIRST_CW),
                .NOUT(`DDCHB_FIRST_NOUT),
                .COEF(`DDCHB_FIRST_COEF),
                .CENTRE(`DDCHB_FIRST_CENTRE)
            ) first_halfband_stage (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .bypass(!stageOn[0]),
                .decimate(1'b1),
                .inValid(stgValid[g][0]),
                .inSample(stgSample[g][0]),
                .outValid(stgValid[g][1]),
                .outSample(stgSample[g][1])
            );

            ddchb_halfband #(
                .NTAP(`DDCHB_SECOND_NTAP),
                .CW(`DDCHB_SECOND_CW),
                .NOUT(`DDCHB_SECOND_NOUT),
                .COEF(`DDCHB_SECOND_COEF),
                .CENTRE(`DDCHB_SECOND_CENTRE)
            ) second_halfband_stage (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .bypass(!stageOn[1]),
                .decimate(1'b1),
                .inValid(stgValid[g][1]),
                .inSample(stgSample[g][1]),
                .outValid(stgValid[g][2]),
                .outSample(stgSample[g][2])
            );

            ddchb_halfband #(
                .NTAP(`DDCHB_THIRD_NTAP),
                .CW(`DDCHB_THIRD_CW),
                .NOUT(`DDCHB_THIRD_NOUT),
                .COEF(`DDCHB_THIRD_COEF),
                .CENTRE(`DDCHB_THIRD_CENTRE)
            ) third_halfband_stage (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .bypass(!stageOn[2]),
                .decimate(1'b1),
                .inValid(stgValid[g][2]),
                .inSample(stgSample[g][2]),
                .outValid(stgValid[g][3]),
                .outSample(stgSample[g][3])
            );

            ddchb_halfband #(
                .NTAP(`DDCHB_FINAL_NTAP),
                .CW(`DDCHB_FINAL_CW),
                .NOUT(`DDCHB_FINAL_NOUT),
                .COEF(`DDCHB_FINAL_COEF),
                .CENTRE(`DDCHB_FINAL_CENTRE)
            ) final_halfband_stage (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .bypass(1'b0),
                .decimate(!state_ff.ctrl[g].toReal),
                .inValid(stgValid[g][3]),
                .inSample(stgSample[g][3]),
                .outValid(stgValid[g][4]),
                .outSample(stgSample[g][4])
            );
        end
    endgenerate

    always_comb begin
        ddchb_sample_t gained;
        gained = '0;
        nxt_state = state_ff;
        nxt_state.ack = 1'b0;
        nxt_state.outValid = 2'b00;

        // classic slave: answer one cycle after the strobe, never two acks in a row
        if (wbCyc && wbStb && !state_ff.ack) begin
            nxt_state.ack = 1'b1;
            nxt_state.rdData = 32'h00000000;
            if (isAddr(wbAdr, `DDCHB_CTRL0_ADDR)) begin
                nxt_state.rdData[7:0] = state_ff.ctrl[0];
            end else if (isAddr(wbAdr, `DDCHB_CTRL1_ADDR)) begin
                nxt_state.rdData[7:0] = state_ff.ctrl[1];
            end else if (isAddr(wbAdr, `DDCHB_STATUS_ADDR)) begin
                nxt_state.rdData[`DDCHB_ST_MASK0_LSB +: 4] = stageMask(state_ff.ctrl[0].decim);
                nxt_state.rdData[`DDCHB_ST_MASK1_LSB +: 4] = stageMask(state_ff.ctrl[1].decim);
                nxt_state.rdData[`DDCHB_ST_CNT0_LSB +: 8] = state_ff.outCount[0];
                nxt_state.rdData[`DDCHB_ST_CNT1_LSB +: 8] = state_ff.outCount[1];
            end
            // unmapped addresses still ack; writes there are dropped
            if (wbWe && wbSel[0]) begin
                if (isAddr(wbAdr, `DDCHB_CTRL0_ADDR)) begin
                    nxt_state.ctrl[0] = ddchb_ctrl_t'(wbDatW[7:0]);
                end
                if (isAddr(wbAdr, `DDCHB_CTRL1_ADDR)) begin
                    nxt_state.ctrl[1] = ddchb_ctrl_t'(wbDatW[7:0]);
                end
            end
        end

        // per converter gain and real conversion, each from its own register
        for (int d = 0; d < 2; d++) begin
            nxt_state.outReal[d] = state_ff.ctrl[d].toReal;
            if (!state_ff.ctrl[d].toReal) begin
                nxt_state.mixPhase[d] = MIX_P0;
            end
            if (stgValid[d][4]) begin
                gained = applyGain(stgSample[d][4], state_ff.ctrl[d].gain6db);
                nxt_state.outValid[d] = 1'b1;
                nxt_state.outCount[d] = state_ff.outCount[d] + 8'h01;
                if (state_ff.ctrl[d].toReal) begin
                    // quarter-rate upward shift of the final-stage output
                    nxt_state.outSample[d].i = upMixReal(gained, state_ff.mixPhase[d]);
                    nxt_state.outSample[d].q = 16'h0000;
                    nxt_state.mixPhase[d] = nextPhase(state_ff.mixPhase[d]);
                end else begin
                    nxt_state.outSample[d] = gained;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= '0;
            state_ff.ctrl[0] <= `DDCHB_CTRL_RESET;
            state_ff.ctrl[1] <= `DDCHB_CTRL_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign wbDatR = state_ff.rdData;
    assign wbAck = state_ff.ack;
    assign outValid = state_ff.outValid;
    assign outSample = state_ff.outSample;
    assign outReal = state_ff.outReal;

endmodule

// ---- tb/ddchb_chain_monitor.sv ----
// Purpose: port-level temporal checks of the decimation chain
// Assumes: bound to ddchb_chain, single clock domain
// Notes: real-mode checks skip outputs still in flight across a mode change
`timescale 1ns/1ps
module ddchb_chain_monitor (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // wishbone
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [11:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    input wire logic [31:0] wbDatR,
    input wire logic wbAck,
    // samples
    input wire logic [1:0] inValid,
    input wire ddchb_pkg::ddchb_sample_t [1:0] inSample,
    input wire logic [1:0] outValid,
    input wire ddchb_pkg::ddchb_sample_t [1:0] outSample,
    input wire logic [1:0] outReal
);
    import ddchb_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    AST_ACK_NEXT: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
        else $error("request not acknowledged next cycle");
    AST_ACK_PULSE: assert property (wbAck |=> !wbAck)
        else $error("ack longer than one cycle");
    AST_ACK_IDLE: assert property (!(wbCyc && wbStb) |=> !wbAck)
        else $error("ack without request");
    AST_RD_UPPER: assert property (wbAck && !wbWe && (wbAdr[11:2] == 10'h0C4
        || wbAdr[11:2] == 10'h0CC) |-> wbDatR[31:8] == 24'h000000)
        else $error("control read has upper bits set");
    AST_CAUSE0: assert property (outValid[0] |-> $past(inValid[0], 5))
        else $error("lane 0 output without input five cycles earlier");
    AST_CAUSE1: assert property (outValid[1] |-> $past(inValid[1], 5))
        else $error("lane 1 output without input five cycles earlier");
    AST_REALQ0: assert property (outValid[0] && outReal[0] && $past(outReal[0], 6)
        |-> outSample[0].q == 16'h0000)
        else $error("real output carries quadrature data");
    AST_DECIM0: assert property (outValid[0] && !outReal[0] && !$past(outReal[0], 8)
        |=> !outValid[0])
        else $error("complex outputs back to back");
    AST_REAL_LEVEL: assert property ($changed(outReal)
        |-> $past(wbAck) || $past(wbAck, 2))
        else $error("real flag changed without a register write");
endmodule

// ---- tb/ddchb_framer_model.sv ----
// Purpose: link framer stand-in that collects every output sample
// Assumes: chain offers no back-pressure
// Notes: queues empty on reset so each scenario starts clean
`timescale 1ns/1ps
module ddchb_framer_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // samples from the chain
    input wire logic [1:0] outValid,
    input wire ddchb_pkg::ddchb_sample_t [1:0] outSample,
    input wire logic [1:0] outReal
);
    import ddchb_pkg::*;
    ddchb_sample_t got[2][$];
    // real flag as it stood beside each sample, so the bench can check the pairing
    bit gotReal[2][$];
    // accepts every pulse: a stall here would silently lose data
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            got[0].delete();
            got[1].delete();
            gotReal[0].delete();
            gotReal[1].delete();
        end else begin
            for (int d = 0; d < 2; d++) begin
                if (outValid[d] === 1'b1) begin
                    got[d].push_back(outSample[d]);
                    gotReal[d].push_back(outReal[d]);
                end
            end
        end
    end
endmodule

// ---- tb/tb_ddchb_chain.sv ----
// Purpose: self-checking bench, integer model of both converter chains
// Assumes: reset between scenarios so filter lines start empty
// Notes: random inputs at full scale also exercise saturation
`timescale 1ns/1ps
module tb_ddchb_chain;
    import ddchb_pkg::*;
    logic clk_sys, rst_n, wbCyc, wbStb, wbWe, wbAck;
    logic [11:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatW, wbDatR, rd;
    logic [1:0] inValid, outValid, outReal;
    ddchb_sample_t [1:0] inSample, outSample;
    int err_total, total_checks;
    // per stage: outer taps outermost first, then the centre tap
    int cf[$] = '{99, -808, 4805, 8192, 859, -6661, 38570, 65536, 161, -1328, 5814,
        -19272, 80160, 131072, -24, 102, -302, 730, -1544, 2964, -5284, 8903, -14383,
        22640, -35476, 57468, -105442, 331792, 524288};
    int off[4] = '{0, 4, 8, 14};
    int nout[4] = '{3, 3, 5, 14};
    int cw[4] = '{15, 18, 19, 21};
    int hist[2][4][2][$];
    bit ph[2][4];
    int mixN[2];
    logic [7:0] ctl[2];
    ddchb_sample_t want[2][$];

    ddchb_chain dut_u (.clk_sys, .rst_n, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW,
        .wbDatR, .wbAck, .inValid, .inSample, .outValid, .outSample, .outReal);
    ddchb_framer_model fw_u (.clk_sys, .rst_n, .outValid, .outSample, .outReal);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic give_verdict();
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic wb(bit we, logic [11:0] a, logic [31:0] d, logic [3:0] sel);
        int k;
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatW <= d;
        wbSel <= sel;
        for (k = 0; k < 20 && wbAck !== 1'b1; k++) @(posedge clk_sys);
        if (k == 20) begin
            err_total++;
            give_verdict();
        end
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    function automatic int sat(longint v);
        return v > 32767 ? 32767 : (v < -32768 ? -32768 : int'(v));
    endfunction

    function automatic bit stageOn(int d, int s);
        return s == 3 || ctl[d][1:0] == 2'h2 || (ctl[d][1:0] == 2'h1 && s > 0)
            || (ctl[d][1:0] == 2'h0 && s > 1);
    endfunction

    function automatic longint tap(int d, int s, int r, int i);
        return i < hist[d][s][r].size() ? longint'(hist[d][s][r][i]) : 0;
    endfunction

    task automatic model(int d, int xi, int xq);
        int x[2];
        int s, r, j, n;
        longint acc;
        x = '{xi, xq};
        for (s = 0; s < 4; s++) begin
            if (stageOn(d, s)) begin
                for (r = 0; r < 2; r++) begin
                    hist[d][s][r].push_front(x[r]);
                end
                if (s < 3 || !ctl[d][3]) begin
                    ph[d][s] = !ph[d][s];
                    if (ph[d][s]) return;
                end
                n = 4 * nout[s] - 1;
                for (r = 0; r < 2; r++) begin
                    acc = cf[off[s] + nout[s]] * tap(d, s, r, 2 * nout[s] - 1);
                    for (j = 0; j < nout[s]; j++)
                        acc += cf[off[s] + j] * (tap(d, s, r, 2 * j) + tap(d, s, r, n - 1 - 2 * j));
                    x[r] = sat((acc + (64'sd1 <<< (cw[s] - 2))) >>> (cw[s] - 1));
                end
            end
        end
        if (ctl[d][6]) begin
            x[0] = sat(2 * longint'(x[0]));
            x[1] = sat(2 * longint'(x[1]));
        end
        if (ctl[d][3]) begin
            case (mixN[d])
                1: x[0] = sat(-longint'(x[1]));
                2: x[0] = sat(-longint'(x[0]));
                3: x[0] = x[1];
                default: x[0] = x[0];
            endcase
            mixN[d] = (mixN[d] + 1) % 4;
            x[1] = 0;
        end
        want[d].push_back(ddchb_sample_t'({x[0][15:0], x[1][15:0]}));
    endtask

    task automatic run(int k);
        int n, d, s;
        logic [1:0] v;
        logic [7:0] ms;
        ddchb_sample_t [1:0] smp;
        ctl[0] = {1'b0, k[2], 2'b00, k[2], 1'b0, k[1:0]};
        ctl[1] = {1'b1, k[0], 2'b10, ~k[2], 1'b1, ~k[1:0]};
        @(posedge clk_sys);
        rst_n <= 1'b0;
        @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (hist[a, b, c]) hist[a][b][c].delete();
        ph = '{default: 1'b0};
        mixN = '{0, 0};
        want[0].delete();
        want[1].delete();
        for (d = 0; d < 2; d++) begin
            wb(1'b1, d ? 12'h330 : 12'h310, {24'h0, ctl[d]}, 4'h1);
            wb(1'b0, d ? 12'h330 : 12'h310, 32'h0, 4'h1);
            chk(rd, {24'h0, ctl[d]}, "ctrl readback");
            for (s = 0; s < 4; s++) ms[4 * d + s] = stageOn(d, s);
        end
        wb(1'b0, 12'h3F0, 32'h0, 4'h1);
        chk(rd, {24'h0, ms}, "stage mask");
        for (n = 0; n < 96; n++) begin
            @(posedge clk_sys);
            v = 2'($urandom);
            smp = {$urandom, $urandom};
            inValid <= v;
            inSample <= smp;
            for (d = 0; d < 2; d++)
                if (v[d]) model(d, int'($signed(smp[d].i)), int'($signed(smp[d].q)));
        end
        @(posedge clk_sys);
        inValid <= 2'h0;
        repeat (10) @(posedge clk_sys);
        chk({30'h0, outReal}, {30'h0, ctl[1][3], ctl[0][3]}, "real flag");
        for (d = 0; d < 2; d++) begin
            chk(fw_u.got[d].size(), want[d].size(), "output count");
            for (n = 0; n < want[d].size() && n < fw_u.got[d].size(); n++) begin
                chk(fw_u.got[d][n], want[d][n], "sample");
                chk({31'h0, fw_u.gotReal[d][n]}, {31'h0, ctl[d][3]}, "real tag");
            end
        end
        // hardware output counters must agree with the model's sample count
        wb(1'b0, 12'h3F0, 32'h0, 4'h1);
        chk(rd, {8'(want[1].size()), 8'(want[0].size()), 8'h00, ms}, "counters");
    endtask

    initial begin
        void'($urandom(14908));
        rst_n = 1'b0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 12'h000;
        wbSel = 4'h0;
        wbDatW = 32'h0;
        inValid = 2'h0;
        inSample = '0;
        err_total = 0;
        total_checks = 0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        wb(1'b0, 12'h310, 32'h0, 4'hF);
        chk(rd, 32'h0, "ctrl reset value");
        wb(1'b0, 12'h100, 32'h0, 4'hF);
        chk(rd, 32'h0, "unmapped read");
        wb(1'b1, 12'h310, 32'hFF, 4'h0);
        wb(1'b0, 12'h310, 32'h0, 4'hF);
        chk(rd, 32'h0, "write with lane off");
        for (int k = 0; k < 8; k++) run(k);
        give_verdict();
    end
endmodule

bind ddchb_chain ddchb_chain_monitor mon_u (.clk_sys, .rst_n, .wbCyc, .wbStb, .wbWe, .wbAdr,
    .wbSel, .wbDatW, .wbDatR, .wbAck, .inValid, .inSample, .outValid, .outSample, .outReal);
